/* File: include/ddrr_pkg.sv */
`default_nettype none
package ddrr_pkg;
   // clock and time figures
   localparam int CLK_PERIOD_PS = 10000;
   localparam int TRCD_PS       = 15000;
   localparam int TRC_PS        = 55000;
   localparam int TRRD_PS       = 10000;
   localparam int TRAS_PS       = 40000;
   localparam int TRTP_PS       = 7500;
   localparam int TRP_PS        = 15000;
   localparam int RTP_MIN_CYC   = 2;

   // least times round up to whole cycles
   localparam logic [5:0] TRCD_CYC = 6'((TRCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [5:0] TRC_CYC  = 6'((TRC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [5:0] TRRD_CYC = 6'((TRRD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [5:0] TRAS_CYC = 6'((TRAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [5:0] TRP_CYC  = 6'((TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int         TRTP_RAW = (TRTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [5:0] TRTP_CYC = 6'((TRTP_RAW > RTP_MIN_CYC) ? TRTP_RAW : RTP_MIN_CYC);
   localparam logic [5:0] CNT_MAX  = 6'h3F;

   // latency and burst figures
   localparam logic [2:0] AL_MAX       = 3'h6;
   localparam logic [2:0] CL_MIN       = 3'h3;
   localparam logic [3:0] PF_BL8_OFS   = 4'h2;
   localparam logic [2:0] BEATS_M1_BL4 = 3'h1;
   localparam logic [2:0] BEATS_M1_BL8 = 3'h3;
   localparam logic [2:0] INTR_LEFT    = 3'h2;
   localparam int         DL_DEPTH     = 12;

   // register map
   localparam logic [7:0]  REG_CFG      = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_VIOL     = 8'h08;
   localparam logic [7:0]  REG_MEM_ADDR = 8'h0C;
   localparam logic [7:0]  REG_MEM_DATA = 8'h10;
   localparam int          CFG_AL_LSB   = 0;
   localparam int          CFG_CL_LSB   = 3;
   localparam int          CFG_BL8_BIT  = 6;
   localparam logic [2:0]  AL_RESET     = 3'h0;
   localparam logic [2:0]  CL_RESET     = 3'h3;
   localparam logic [19:0] PIN_RESET    = 20'hF_FFFF;

   // violation flag positions
   localparam int V_ACT_OPEN = 0;
   localparam int V_TRC      = 1;
   localparam int V_TRCD     = 2;
   localparam int V_PRE      = 3;
   localparam int V_TRP      = 4;
   localparam int V_TRRD     = 5;
   localparam int V_INTR     = 6;
   localparam int V_CFG      = 7;
endpackage : ddrr_pkg
`default_nettype wire

/* File: core/ddrr_rdmem.sv */
`default_nettype none
module ddrr_rdmem
   import ddrr_pkg::*;
#(
   parameter int W  = 16,
   parameter int AW = 5
)(
   input  wire logic          clk_sys,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem_reg [2**AW];

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem_reg[waddr] <= wdata;
      end
      if (rd_en)
      begin
         rdata <= mem_reg[raddr];
      end
   end
endmodule : ddrr_rdmem
`default_nettype wire

/* File: core/ddrr_bank.sv */
`default_nettype none
module ddrr_bank
   import ddrr_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       act,
   input  wire logic       rd,
   input  wire logic       pf,
   input  wire logic       ap_arm,
   input  wire logic [3:0] ap_dly,
   input  wire logic       pre,
   output logic            bank_open,
   output logic            ap_fire,
   output logic      [4:0] viol
);
   logic [5:0] since_act_reg;
   logic [5:0] since_pf_reg;
   logic [5:0] since_pre_reg;
   logic [3:0] ap_cnt_reg;
   logic       ap_pend_reg;
   logic       open_reg;

   wire tras_ok = since_act_reg >= TRAS_CYC;
   wire rtp_ok  = since_pf_reg >= TRTP_CYC;
   wire cmd_any = act | rd | pre;
   // internal precharge waits for row-active and read-to-precharge
   assign ap_fire   = ap_pend_reg & (ap_cnt_reg == 4'h0) & tras_ok & rtp_ok; // [RQ21]
   assign bank_open = open_reg;
   wire close = pre | ap_fire;

   assign viol[V_ACT_OPEN] = act & open_reg; // [RQ25]
   assign viol[V_TRC]      = act & (since_act_reg < TRC_CYC);
   assign viol[V_TRCD]     = rd & (~open_reg | (since_act_reg < TRCD_CYC));
   assign viol[V_PRE]      = pre & open_reg & (~tras_ok | ~rtp_ok | ap_pend_reg);
   assign viol[V_TRP]      = cmd_any & (since_pre_reg < TRP_CYC);

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         since_act_reg <= CNT_MAX;
         since_pf_reg  <= CNT_MAX;
         since_pre_reg <= CNT_MAX;
         ap_cnt_reg    <= 4'h0;
         ap_pend_reg   <= 1'b0;
         open_reg      <= 1'b0;
      end
      else
      begin
         // counters read one in the cycle after their event, so a limit of n cycles is met at n
         since_act_reg <= act ? 6'h01 : (since_act_reg == CNT_MAX ? CNT_MAX : since_act_reg + 6'h01);
         since_pf_reg  <= pf ? 6'h01 : (since_pf_reg == CNT_MAX ? CNT_MAX : since_pf_reg + 6'h01); // [RQ17]
         // precharge interval counts from the actual internal instant
         since_pre_reg <= close ? 6'h01 : (since_pre_reg == CNT_MAX ? CNT_MAX : since_pre_reg + 6'h01); // [RQ22]
         if (ap_arm)
         begin
            ap_pend_reg <= 1'b1; // [RQ6]
            ap_cnt_reg  <= ap_dly - 4'h1;
         end
         else
         begin
            ap_pend_reg <= ap_pend_reg & ~ap_fire;
            ap_cnt_reg  <= (ap_cnt_reg == 4'h0) ? 4'h0 : ap_cnt_reg - 4'h1;
         end
         open_reg <= act | (open_reg & ~close);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_ap_waits_times: assert property (ap_fire |-> since_act_reg >= TRAS_CYC && since_pf_reg >= TRTP_CYC) // [RQ21]
      else $error("auto precharge started before row-active or read-to-precharge time");
   a_trp_from_fire: assert property (ap_fire |=> since_pre_reg == 6'h01 && !open_reg) // [RQ22]
      else $error("precharge interval did not start at the internal precharge");
   c_ap_fire: cover property (ap_fire);
endmodule : ddrr_bank
`default_nettype wire

/* File: core/ddrr_core.sv */
// Behaviour
// [RQ1] controller activates a row in a bank before any read or write to it
// [RQ2] controller turns time limits into cycles, rounding fractions up
// [RQ3] same-bank activations need a precharge between and row cycle time apart
// [RQ4] activations to different banks are at least row-to-row delay apart
// [RQ5] four-activate window applies only to eight-bank parts, not this one
// [RQ6] read carries column, bank and auto precharge choice; precharge closes row
// [RQ7] first read data appear read latency (additive plus CAS) after read
// [RQ8] following data elements come one per clock half-cycle
// [RQ9] strobe low, complement high as preamble before data and postamble at end
// [RQ10] data lines released once a burst ends with nothing following
// [RQ11] read issued half a burst after another gives seamless data
// [RQ12] burst-of-four reads are never interrupted by the controller
// [RQ13] burst-of-eight read truncated only by a read on four-element boundary
// [RQ14] interrupting read exactly two clocks later; no precharge to those banks
// [RQ15] controller lets read data finish before a write burst
// [RQ16] explicit precharge after plain read waits additive plus half burst
// [RQ17] read-to-precharge time counts from edge of last four-element prefetch
// [RQ18] read-to-precharge spacing uses larger of two clocks or that time
// [RQ19] no command to a bank until row precharge time after precharge
// [RQ20] address bit ten high on read selects auto precharge
// [RQ21] auto precharge at additive plus half burst, held for row-active and rtp
// [RQ22] precharge interval starts at the actual internal precharge instant
// [RQ23] read held internally for additive latency before it executes
// [RQ24] additive latency zero to six; other codes rejected
// [RQ25] each bank tracks open state and its elapsed-time counters
//
// The plain strobed port and the register offsets were chosen for this implementation.
`default_nettype none
module ddrr_core
   import ddrr_pkg::*;
#(
   parameter int DQ_W   = 8,
   parameter int MEM_AW = 5
)(
   input  wire logic            clk_sys,
   input  wire logic            rstn,
   input  wire logic            cs_n,
   input  wire logic            ras_n,
   input  wire logic            cas_n,
   input  wire logic            we_n,
   input  wire logic [1:0]      ba,
   input  wire logic [13:0]     addr,
   output logic      [DQ_W-1:0] dq_rise,
   output logic      [DQ_W-1:0] dq_fall,
   output logic                 dq_oe_n,
   output logic                 dqs_rise,
   output logic                 dqs_fall,
   output logic                 dqsn_rise,
   output logic                 dqsn_fall,
   output logic                 dqs_oe_n,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [31:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [31:0]     reg_rdata
);
   // pin synchroniser, stage one read only by stage two
   logic [19:0] pin_s1_reg;
   logic [19:0] pin_s2_reg;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_s1_reg <= PIN_RESET;
         pin_s2_reg <= PIN_RESET;
      end
      else
      begin
         pin_s1_reg <= {cs_n, ras_n, cas_n, we_n, ba, addr};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   wire        p_cs_n  = pin_s2_reg[19];
   wire        p_ras_n = pin_s2_reg[18];
   wire        p_cas_n = pin_s2_reg[17];
   wire        p_we_n  = pin_s2_reg[16];
   wire [1:0]  p_ba    = pin_s2_reg[15:14];
   wire [13:0] p_addr  = pin_s2_reg[13:0];

   wire cmd_act = ~p_cs_n & ~p_ras_n & p_cas_n & p_we_n;
   wire cmd_rd  = ~p_cs_n & p_ras_n & ~p_cas_n & p_we_n;
   wire cmd_pre = ~p_cs_n & ~p_ras_n & p_cas_n & ~p_we_n;
   wire cmd_ap  = p_addr[10]; // [RQ20]
   wire [3:0] bank_sel = 4'h1 << p_ba;

   // configuration and status registers
   logic [2:0]          cfg_al_reg;
   logic [2:0]          cfg_cl_reg;
   logic                cfg_bl8_reg;
   logic [MEM_AW-1:0]   mem_addr_reg;
   logic [7:0]          viol_reg;
   logic [31:0]         rdata_reg;
   logic [7:0]          viol_set;

   wire sel_cfg    = reg_addr == REG_CFG;
   wire sel_status = reg_addr == REG_STATUS;
   wire sel_viol   = reg_addr == REG_VIOL;
   wire sel_maddr  = reg_addr == REG_MEM_ADDR;
   wire sel_mdata  = reg_addr == REG_MEM_DATA;

   wire [2:0] wr_al    = reg_wdata[CFG_AL_LSB +: 3];
   wire [2:0] wr_cl    = reg_wdata[CFG_CL_LSB +: 3];
   wire       cfg_ok   = (wr_al <= AL_MAX) & (wr_cl >= CL_MIN);
   wire       cfg_load = reg_wr & sel_cfg & cfg_ok; // [RQ24]
   wire       cfg_bad  = reg_wr & sel_cfg & ~cfg_ok;
   wire       mem_wr   = reg_wr & sel_mdata;

   // read delay line: index d holds a read decoded d cycles ago
   logic [DL_DEPTH-1:0]      dl_vld_reg;
   logic [DL_DEPTH-1:0][1:0] dl_bank_reg;
   logic [DL_DEPTH-1:0][2:0] dl_pair_reg;

   wire [DL_DEPTH:0]      all_vld  = {dl_vld_reg, cmd_rd};
   wire [DL_DEPTH:0][1:0] all_bank = {dl_bank_reg, p_ba};
   wire [DL_DEPTH:0][2:0] all_pair = {dl_pair_reg, p_addr[3:1]};

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         dl_vld_reg  <= '0;
         dl_bank_reg <= '0;
         dl_pair_reg <= '0;
      end
      else
      begin
         dl_vld_reg  <= all_vld[DL_DEPTH-1:0];
         dl_bank_reg <= all_bank[DL_DEPTH-1:0];
         dl_pair_reg <= all_pair[DL_DEPTH-1:0];
      end
   end

   wire [3:0] al_d   = {1'b0, cfg_al_reg};
   wire [3:0] rl_d   = al_d + {1'b0, cfg_cl_reg}; // [RQ7]
   wire [3:0] pf_d   = al_d + (cfg_bl8_reg ? PF_BL8_OFS : 4'h0); // [RQ17]
   wire [3:0] ap_dly = al_d + (cfg_bl8_reg ? 4'h4 : 4'h2); // [RQ21]
   // held read executes internally after additive latency
   wire       al_vld  = all_vld[al_d]; // [RQ23]
   wire [1:0] al_bank = all_bank[al_d];
   wire       pf_vld  = all_vld[pf_d];
   wire [1:0] pf_bank = all_bank[pf_d];
   wire       pre_tap = all_vld[rl_d - 4'h2];
   wire       fstart  = all_vld[rl_d - 4'h1];
   wire [1:0] fs_bank = all_bank[rl_d - 4'h1];
   wire [2:0] fs_pair = all_pair[rl_d - 4'h1];

   // per-bank state
   logic [3:0]      bank_open;
   logic [3:0]      bank_ap;
   logic [3:0][4:0] bank_viol;

   for (genvar g = 0; g < 4; g++)
   begin : g_bank
      ddrr_bank u_bank (
         .clk_sys   (clk_sys),
         .rstn      (rstn),
         .act       (cmd_act & bank_sel[g]),
         .rd        (al_vld & (al_bank == 2'(g))),
         .pf        (pf_vld & (pf_bank == 2'(g))),
         .ap_arm    (cmd_rd & cmd_ap & bank_sel[g]),
         .ap_dly    (ap_dly),
         .pre       (cmd_pre & (bank_sel[g] | p_addr[10])),
         .bank_open (bank_open[g]),
         .ap_fire   (bank_ap[g]),
         .viol      (bank_viol[g])
      );
   end

   // any-bank activate spacing
   logic [5:0] since_any_act_reg;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         since_any_act_reg <= CNT_MAX;
      end
      else
      begin
         since_any_act_reg <= cmd_act ? 6'h01 :
                              (since_any_act_reg == CNT_MAX ? CNT_MAX : since_any_act_reg + 6'h01);
      end
   end

   // burst fetch: one element pair per clock
   logic [2:0]        fetch_cnt_reg;
   logic [2:0]        fetch_pair_reg;
   logic [1:0]        fetch_bank_reg;
   logic              out_vld_reg;
   logic              pre_reg;
   logic              post_reg;
   logic [2*DQ_W-1:0] mem_rdata;

   function automatic logic [2:0] pair_next(input logic [2:0] p, input logic bl8);
      pair_next = bl8 ? {p[2], p[1:0] + 2'h1} : {p[2:1], ~p[0]};
   endfunction : pair_next

   wire [2:0] beats_m1  = cfg_bl8_reg ? BEATS_M1_BL8 : BEATS_M1_BL4;
   wire       fetch_act = fstart | (fetch_cnt_reg != 3'h0);
   wire [MEM_AW-1:0] mem_raddr = MEM_AW'(fstart ? {fs_bank, fs_pair} : {fetch_bank_reg, fetch_pair_reg});
   // a read landing mid-burst is legal only at the boundary of a burst of eight
   wire bad_intr = fstart & (fetch_cnt_reg != 3'h0) & ~(cfg_bl8_reg & (fetch_cnt_reg == INTR_LEFT)); // [RQ13]

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         fetch_cnt_reg  <= 3'h0;
         fetch_pair_reg <= 3'h0;
         fetch_bank_reg <= 2'h0;
      end
      else if (fstart)
      begin
         // a new read reloads, giving seamless or truncated bursts
         fetch_cnt_reg  <= beats_m1; // [RQ11] [RQ13]
         fetch_pair_reg <= pair_next(fs_pair, cfg_bl8_reg);
         fetch_bank_reg <= fs_bank;
      end
      else if (fetch_cnt_reg != 3'h0)
      begin
         fetch_cnt_reg  <= fetch_cnt_reg - 3'h1; // [RQ8]
         fetch_pair_reg <= pair_next(fetch_pair_reg, cfg_bl8_reg);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         out_vld_reg <= 1'b0;
         pre_reg     <= 1'b0;
         post_reg    <= 1'b0;
      end
      else
      begin
         out_vld_reg <= fetch_act; // [RQ7] [RQ10]
         pre_reg     <= pre_tap; // [RQ9]
         post_reg    <= out_vld_reg & ~fetch_act; // [RQ9]
      end
   end

   ddrr_rdmem #(
      .W  (2*DQ_W),
      .AW (MEM_AW)
   ) u_mem (
      .clk_sys (clk_sys),
      .wr_en   (mem_wr),
      .waddr   (mem_addr_reg),
      .wdata   (reg_wdata[2*DQ_W-1:0]),
      .rd_en   (fetch_act),
      .raddr   (mem_raddr),
      .rdata   (mem_rdata)
   );

   assign dq_rise   = mem_rdata[DQ_W-1:0]; // [RQ8]
   assign dq_fall   = mem_rdata[2*DQ_W-1:DQ_W];
   assign dq_oe_n   = ~out_vld_reg; // [RQ10]
   assign dqs_rise  = out_vld_reg; // [RQ9]
   assign dqs_fall  = 1'b0;
   assign dqsn_rise = ~out_vld_reg;
   assign dqsn_fall = 1'b1;
   assign dqs_oe_n  = ~(pre_reg | out_vld_reg | post_reg);

   // violation gathering
   always_comb
   begin
      viol_set = '0;
      for (int i = 0; i < 4; i++)
      begin
         viol_set[4:0] = viol_set[4:0] | bank_viol[i]; // [RQ25]
      end
      viol_set[V_TRRD] = cmd_act & (since_any_act_reg < TRRD_CYC);
      viol_set[V_INTR] = bad_intr;
      viol_set[V_CFG]  = cfg_bad;
   end

   wire [7:0] viol_clr = (reg_wr & sel_viol) ? reg_wdata[7:0] : 8'h00;

   wire [31:0] rd_mux = sel_cfg    ? 32'({cfg_bl8_reg, cfg_cl_reg, cfg_al_reg}) :
                        sel_status ? 32'({|bank_ap, out_vld_reg, bank_open}) :
                        sel_viol   ? 32'(viol_reg) :
                        sel_maddr  ? 32'(mem_addr_reg) : 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_al_reg   <= AL_RESET;
         cfg_cl_reg   <= CL_RESET;
         cfg_bl8_reg  <= 1'b0;
         mem_addr_reg <= '0;
         viol_reg     <= 8'h00;
         rdata_reg    <= 32'h0000_0000;
      end
      else
      begin
         if (cfg_load)
         begin
            cfg_al_reg  <= wr_al;
            cfg_cl_reg  <= wr_cl;
            cfg_bl8_reg <= reg_wdata[CFG_BL8_BIT];
         end
         if (reg_wr & sel_maddr)
         begin
            mem_addr_reg <= reg_wdata[MEM_AW-1:0];
         end
         else if (mem_wr)
         begin
            mem_addr_reg <= mem_addr_reg + 1'b1;
         end
         // set wins over write-one-to-clear
         viol_reg  <= (viol_reg & ~viol_clr) | viol_set;
         rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_reg;

   // latency helper for checks
   logic       lat_run_reg;
   logic [3:0] lat_cnt_reg;
   wire        path_idle = ~(|dl_vld_reg) & ~fetch_act & ~out_vld_reg;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         lat_run_reg <= 1'b0;
         lat_cnt_reg <= 4'h0;
      end
      else if (cmd_rd & path_idle & ~lat_run_reg)
      begin
         lat_run_reg <= 1'b1;
         lat_cnt_reg <= 4'h1;
      end
      else if (lat_run_reg)
      begin
         lat_run_reg <= dq_oe_n;
         lat_cnt_reg <= lat_cnt_reg + 4'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_read_latency: assert property (lat_run_reg && $fell(dq_oe_n) |-> lat_cnt_reg == rl_d) // [RQ7]
      else $error("first read data not at read latency");
   a_burst_min_len: assert property ($fell(dq_oe_n) |-> !dq_oe_n [*2]) // [RQ8]
      else $error("burst shorter than two clocks");
   a_burst_eight_len: assert property ($fell(dq_oe_n) && cfg_bl8_reg |-> !dq_oe_n [*4]) // [RQ8]
      else $error("burst of eight shorter than four clocks");
   a_strobe_preamble: assert property ($fell(dqs_oe_n) |-> !dqs_rise && dqsn_rise ##1 !dq_oe_n) // [RQ9]
      else $error("strobe preamble missing before data");
   a_strobe_postamble: assert property ($rose(dq_oe_n) |-> !dqs_oe_n && !dqs_rise) // [RQ9]
      else $error("strobe postamble missing after data");
   a_data_release: assert property (!dq_oe_n && !fetch_act |=> dq_oe_n) // [RQ10]
      else $error("data lines not released after burst");
   a_seamless_read: assert property (fstart && !dq_oe_n |=> !dq_oe_n && dqs_rise) // [RQ11]
      else $error("concatenated read left a gap");
   a_bad_intr_flag: assert property (bad_intr |=> viol_reg[V_INTR]) // [RQ13]
      else $error("illegal read interruption not flagged");
   a_al_legal: assert property (cfg_al_reg <= AL_MAX && cfg_cl_reg >= CL_MIN) // [RQ24]
      else $error("reserved latency accepted");
   a_ap_decode: assert property (cmd_rd && cmd_ap && p_ba == 2'h1 |=> g_bank[1].u_bank.ap_pend_reg) // [RQ20]
      else $error("auto precharge read not armed");
   a_viol_set_wins: assert property (viol_set != 8'h00 |=> (viol_reg & $past(viol_set)) == $past(viol_set))
      else $error("violation flag lost on clear");
   a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");

   c_seamless: cover property (fstart && out_vld_reg && fetch_cnt_reg == 3'h0);
   c_interrupt: cover property (fstart && cfg_bl8_reg && fetch_cnt_reg == INTR_LEFT);
   c_violation: cover property (viol_set != 8'h00);
   c_ap_any: cover property (|bank_ap);
endmodule : ddrr_core
`default_nettype wire

/* File: tb/ddrr_ctrl_model.sv */
`default_nettype none
module ddrr_ctrl_model
   import ddrr_pkg::*;
(
   input  wire logic        clk_sys,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic      [1:0]  ba,
   output logic      [13:0] addr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cs_n, ras_n, cas_n, we_n, ba, addr} = '1;
   // one command for one cycle; k is {ras_n, cas_n, we_n}
   task automatic issue(input logic [2:0] k, input logic [1:0] b, input logic [13:0] a);
      @(posedge clk_sys);
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= k;
      ba <= b;
      addr <= a;
   endtask : issue
   // deselect; address keeps toggling so no stale value lingers
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         cs_n <= 1'b1;
         addr <= ~addr;
      end
   endtask : idle
endmodule : ddrr_ctrl_model
`default_nettype wire

/* File: tb/tb_ddrr_activate_read_timing.sv */
`default_nettype none
module tb_ddrr_activate_read_timing
   import ddrr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int t; logic [15:0] d;} ddrr_exp_t;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   wire logic   cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_rise, dqs_fall, dqsn_rise, dqsn_fall, dqs_oe_n;
   wire logic [1:0]  ba;
   wire logic [13:0] addr;
   wire logic [7:0]  dq_rise, dq_fall;
   wire logic [31:0] reg_rdata;
   int          n_fail = 0, n_tests = 0, cyc = 0, seed = 32'h211a_1473;
   logic [15:0] mem [32];
   ddrr_exp_t   dq_q [$];
   logic [31:0] rg_q [$];
   logic        rd_q = 1'b0, was_dat = 1'b0, bl8 = 1'b0;
   logic [2:0]  al = 3'h0, cl = 3'h3;
   logic [6:0]  cfg_tab [4] = '{7'h18, 7'h59, 7'h3E, 7'h63};

   always #5 clk_sys = ~clk_sys;

   ddrr_ctrl_model i_ctrl (.clk_sys(clk_sys), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .ba(ba), .addr(addr));
   ddrr_core #(.DQ_W(8), .MEM_AW(5)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_rise(dq_rise), .dq_fall(dq_fall),
      .dq_oe_n(dq_oe_n), .dqs_rise(dqs_rise), .dqs_fall(dqs_fall), .dqsn_rise(dqsn_rise),
      .dqsn_fall(dqsn_fall), .dqs_oe_n(dqs_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp(got, exp);
   endtask : cmp_reg

   task automatic cmp_dq(input logic [31:0] got, input logic [31:0] exp);
      cmp(got, exp);
   endtask : cmp_dq

   task automatic cmp_dqs(input logic [31:0] got, input logic [31:0] exp);
      cmp(got, exp);
   endtask : cmp_dqs

   task automatic final_report();
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rr(input logic [7:0] a, input logic [31:0] e);
      rg_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rr

   // read command; notes n data cycles at the expected times
   task automatic rd(input logic [1:0] b, input logic [2:0] p, input logic ap, input int n);
      int t;
      int r;
      r = $random(seed);
      i_ctrl.issue(3'b101, b, {r[13:11], ap, r[9:4], p, r[0]});
      t = cyc + 3 + al + cl;
      for (int i = 0; i < n; i++)
         dq_q.push_back('{t + i, mem[{b, bl8 ? {p[2], 2'(p[1:0] + i)} : p ^ 3'(i)}]});
   endtask : rd

   always @(posedge clk_sys)
   begin
      ddrr_exp_t e;
      cyc <= cyc + 1;
      if (rd_q)
         cmp_reg(reg_rdata, rg_q.pop_front());
      rd_q = reg_rd;
      if (dq_oe_n === 1'b0)
      begin
         e.t = -1;
         if (dq_q.size() != 0)
            e = dq_q.pop_front();
         cmp_dq(cyc, e.t);
         cmp_dq({dq_fall, dq_rise}, e.d);
         cmp_dqs({dqs_rise, dqsn_rise, dqs_fall, dqsn_fall}, 4'b1001);
      end
      else if (was_dat)
         cmp_dqs({dqs_oe_n, dqs_rise, dqsn_rise}, 3'b001);
      was_dat = (dq_oe_n === 1'b0);
      if (cyc > 6000)
      begin
         n_fail++;
         final_report();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      rr(REG_CFG, 32'h0000_0018);
      rr({1'b1, 7'($random(seed))}, 32'h0000_0000);
      wr(REG_MEM_ADDR, 32'h0000_0000);
      for (int i = 0; i < 32; i++)
      begin
         mem[i] = 16'($random(seed));
         wr(REG_MEM_DATA, {16'($random(seed)), mem[i]});
      end
      wr(REG_CFG, 32'h0000_001F);
      rr(REG_CFG, 32'h0000_0018);
      rr(REG_VIOL, 32'h0000_0080);
      wr(REG_VIOL, 32'h0000_00FF);
      for (int c = 0; c < 4; c++)
      begin
         {bl8, cl, al} = cfg_tab[c];
         wr(REG_CFG, {25'h0, bl8, cl, al});
         i_ctrl.issue(3'b011, 2'(c), 14'($random(seed)));
         i_ctrl.idle(3);
         rd(2'(c), 3'(c), 1'b0, bl8 ? 4 : 2);
         i_ctrl.idle(bl8 ? 3 : 1);
         rd(2'(c), 3'(c + 5), 1'b0, bl8 ? 4 : 2);
         i_ctrl.idle(24);
         i_ctrl.issue(3'b010, 2'(c), 14'($random(seed)) & 14'h3BFF);
         i_ctrl.idle(4);
      end
      {bl8, cl, al} = 7'h58;
      wr(REG_CFG, 32'h0000_0058);
      i_ctrl.issue(3'b011, 2'd1, 14'($random(seed)));
      i_ctrl.idle(3);
      rd(2'd1, 3'd2, 1'b0, 2);
      i_ctrl.idle(1);
      rd(2'd1, 3'd5, 1'b1, 4);
      i_ctrl.idle(30);
      rr(REG_STATUS, 32'h0000_0000);
      rr(REG_VIOL, 32'h0000_0000);
      i_ctrl.issue(3'b011, 2'd3, 14'($random(seed)));
      rd(2'd3, 3'd0, 1'b0, 4);
      i_ctrl.idle(20);
      rr(REG_VIOL, 32'h0000_0004);
      // read one clock after a read: off the four-element boundary
      rd(2'd3, 3'd1, 1'b0, 1);
      rd(2'd3, 3'd6, 1'b0, 4);
      i_ctrl.idle(20);
      rr(REG_VIOL, 32'h0000_0044);
      repeat (3) @(posedge clk_sys);
      cmp_dq(dq_q.size() + rg_q.size(), 32'h0000_0000);
      final_report();
   end
endmodule : tb_ddrr_activate_read_timing
`default_nettype wire
